// >>> src/vpie_top.sv
// Notes on behaviour
// [RULE1] Channel 0 set write is ignored unless its master enable is one.
// [RULE2] Software writes master enable first, then the set bit.
// [RULE3] Writing one to channel 0 clear drops the active set bit only while its master enable is one.
// [RULE4] Writing zero to a set bit changes nothing.
// [RULE5] Error clear acts only when error master and set bits are one.
// [RULE6] Error clear write of one disables; zero does nothing; reads zero.
// [RULE7] Channel 3 clear acts only when its master and set bits are one.
// [RULE8] Software enables master and set before writing a clear bit.
// [RULE9] Clear register bits 31 to 5 are reserved and read zero.
// [RULE10] An event reaches its output only while its set bit is active.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
module vpie_top #(
    parameter int unsigned ADDR_W = 32 // Bus address width
) (
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic hsel, // Slave select
    input wire logic [ADDR_W-1:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic hready, // Bus ready in
    input wire logic [31:0] hwdata, // Write data
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire logic [4:0] src_event, // Raw source event pulses
    output logic [4:0] irq_out // Gated event pulses
);
    localparam int unsigned NS = vpie_pkg::NUM_SRC;

    // Address-phase decode, registered for the write data phase
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic hreadyout_reg;
    logic hresp_reg;
    logic [NS-1:0] master_en_reg;
    logic [NS-1:0] master_en_next;
    logic [NS-1:0] en_set;
    logic [NS-1:0] set_wr;
    logic [NS-1:0] clr_wr;
    logic [NS-1:0] set_pred;
    logic [NS-1:0] clr_pred;
    logic [NS-1:0] irq_pulse;
    logic addr_take;
    logic [7:0] addr_low;

    // Match a decoded low address against a register offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign addr_low = haddr[7:0];
    assign addr_take = hsel && htrans[1] && hready;

    // Write strobes of the data phase, one bit per source
    always_comb begin
        set_wr = '0;
        clr_wr = '0;
        if (wr_pend_reg && hit(wr_addr_reg, vpie_pkg::OFF_EN_SET)) begin
            set_wr = hwdata[NS-1:0]; // see [RULE4]
        end
        if (wr_pend_reg && hit(wr_addr_reg, vpie_pkg::OFF_EN_CLEAR)) begin
            clr_wr = hwdata[NS-1:0]; // see [RULE6]
        end
    end

    // One enable cell per source; clear gating is the same for all
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_src
            vpie_enable_cell u_cell (
                .clk_sys(clk_sys),
                .reset(reset),
                .master_en(master_en_reg[gi]),
                .set_wr(set_wr[gi]),
                .clr_wr(clr_wr[gi]), // see [RULE5] see [RULE7]
                .src_event(src_event[gi]),
                .en_set(en_set[gi]),
                .irq_pulse(irq_pulse[gi])
            );
        end
    endgenerate

    // Predicted enable state after this edge, so reads see fresh writes
    always_comb begin
        for (int i = 0; i < NS; i++) begin
            set_pred[i] = set_wr[i] && master_en_reg[i];
            clr_pred[i] = clr_wr[i] && master_en_reg[i] && en_set[i];
        end
    end

    // Bus slave next state; zero wait states, reads bypass the write
    always_comb begin
        logic [NS-1:0] set_after;
        set_after = (en_set | set_pred) & ~clr_pred;
        master_en_next = master_en_reg;
        if (wr_pend_reg && hit(wr_addr_reg, vpie_pkg::OFF_MASTER_EN)) begin
            master_en_next = hwdata[NS-1:0];
        end
        wr_pend_next = addr_take && hwrite;
        wr_addr_next = addr_take ? addr_low : wr_addr_reg;
        hrdata_next = hrdata_reg;
        if (addr_take && !hwrite) begin
            // Clear word is write-only; unmapped words read zero
            hrdata_next = vpie_pkg::RD_ZERO; // see [RULE6] see [RULE9]
            if (hit(addr_low, vpie_pkg::OFF_MASTER_EN)) begin
                hrdata_next[NS-1:0] = master_en_next;
            end
            if (hit(addr_low, vpie_pkg::OFF_EN_SET)) begin
                hrdata_next[NS-1:0] = set_after;
            end
        end
    end

    // Bus slave registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= vpie_pkg::RST_RDATA;
            hreadyout_reg <= 1'b1;
            hresp_reg <= vpie_pkg::HRESP_OKAY;
            master_en_reg <= vpie_pkg::RST_MASTER_EN;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg <= vpie_pkg::HRESP_OKAY;
            master_en_reg <= master_en_next;
        end
    end

    // Gated events leave through one more flop so outputs stay registered
    logic [NS-1:0] irq_out_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_out_reg <= '0;
        end else begin
            irq_out_reg <= irq_pulse; // see [RULE10]
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign irq_out = irq_out_reg;

    // Helper: address phase of a read of the clear word
    logic rd_clr;
    assign rd_clr = addr_take && !hwrite
        && hit(addr_low, vpie_pkg::OFF_EN_CLEAR);

    // Channel 0 set write without master enable keeps the bit at zero
    property p_ch0_set_gated;
        @(posedge clk_sys) disable iff (reset)
        (set_wr[0] && !master_en_reg[0] && !en_set[0]) |=> !en_set[0];
    endproperty
    a_ch0_set_gated: assert property (p_ch0_set_gated) // see [RULE1]
        else $error("ch0 set bit rose without master enable");

    // Channel 0 clear while active drops the set bit next cycle
    property p_ch0_clear;
        @(posedge clk_sys) disable iff (reset)
        (clr_wr[0] && master_en_reg[0] && en_set[0]) |=> !en_set[0];
    endproperty
    a_ch0_clear: assert property (p_ch0_clear) // see [RULE3]
        else $error("ch0 clear write did not drop the set bit");

    // Writing zero to ch0 set bit leaves it as it was
    property p_ch0_zero_write;
        @(posedge clk_sys) disable iff (reset)
        (wr_pend_reg && hit(wr_addr_reg, vpie_pkg::OFF_EN_SET)
            && !hwdata[0]) |=> (en_set[0] == $past(en_set[0]));
    endproperty
    a_ch0_zero_write: assert property (p_ch0_zero_write) // see [RULE4]
        else $error("ch0 set bit changed on a zero write");

    // Error clear without both enables is ignored
    property p_err_clear_gated;
        @(posedge clk_sys) disable iff (reset)
        (clr_wr[4] && !(master_en_reg[4] && en_set[4]))
            |=> (en_set[4] == $past(en_set[4]));
    endproperty
    a_err_clear_gated: assert property (p_err_clear_gated) // see [RULE5]
        else $error("error clear acted without both enables");

    // Error clear with both enables disables the error source
    property p_err_clear;
        @(posedge clk_sys) disable iff (reset)
        (clr_wr[4] && master_en_reg[4] && en_set[4]) |=> !en_set[4];
    endproperty
    a_err_clear: assert property (p_err_clear) // see [RULE6]
        else $error("error clear write did not disable the source");

    // Channel 3 clear without both enables is ignored
    property p_ch3_clear_gated;
        @(posedge clk_sys) disable iff (reset)
        (clr_wr[3] && !(master_en_reg[3] && en_set[3]))
            |=> (en_set[3] == $past(en_set[3]));
    endproperty
    a_ch3_clear_gated: assert property (p_ch3_clear_gated) // see [RULE7]
        else $error("ch3 clear acted without both enables");

    // Clear word reads zero in all bits, reserved ones included
    property p_clear_reads_zero;
        @(posedge clk_sys) disable iff (reset)
        rd_clr |=> (hrdata == 32'h0000_0000);
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) // see [RULE9]
        else $error("clear register read returned nonzero data");

    // Channel 0 output pulse only two cycles after an event on enabled channel 0
    property p_forward;
        @(posedge clk_sys) disable iff (reset)
        irq_out[0] |-> $past(src_event[0] && en_set[0], 2);
    endproperty
    a_forward: assert property (p_forward) // see [RULE10]
        else $error("ch0 output pulsed without an enabled event");

    // Slave never stalls and always answers OKAY
    property p_bus_okay;
        @(posedge clk_sys) disable iff (reset)
        hreadyout && (hresp == vpie_pkg::HRESP_OKAY);
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("slave stalled or answered with an error");

    // Enable then set sequence on channel 0
    c_ch0_enable: cover property (@(posedge clk_sys) disable iff (reset)
        set_wr[0] && master_en_reg[0] ##1 en_set[0]);
    // Error source disabled by a clear write
    c_err_clear: cover property (@(posedge clk_sys) disable iff (reset)
        clr_wr[4] && master_en_reg[4] && en_set[4] ##1 !en_set[4]);
    // Event forwarded on channel 3
    c_ch3_forward: cover property (@(posedge clk_sys) disable iff (reset)
        src_event[3] && en_set[3] ##2 irq_out[3]);
endmodule : vpie_top

// >>> src/vpie_pkg.sv
package vpie_pkg;
    // Number of interrupt sources handled by the enable gate
    localparam int unsigned NUM_SRC = 5;
    // Bit position of each source in the three enable registers
    localparam int unsigned BIT_CH0_FRAME = 0;
    localparam int unsigned BIT_CH1_FRAME = 1;
    localparam int unsigned BIT_CH2_FRAME = 2;
    localparam int unsigned BIT_CH3_FRAME = 3;
    localparam int unsigned BIT_ERROR = 4;
    // Register byte offsets inside the slave window
    localparam logic [7:0] OFF_MASTER_EN = 8'h00;
    localparam logic [7:0] OFF_EN_SET = 8'h04;
    localparam logic [7:0] OFF_EN_CLEAR = 8'h08;
    // Low address bits decoded by the slave
    localparam int unsigned DEC_BITS = 8;
    // Reset values
    localparam logic [4:0] RST_MASTER_EN = 5'h00;
    localparam logic [4:0] RST_EN_SET = 5'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    // Bus encodings
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    // Read value of the write-only clear register and of unmapped words
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : vpie_pkg

// >>> src/vpie_enable_cell.sv
module vpie_enable_cell (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic master_en, // Master enable of this source
    input wire logic set_wr, // One written to the set bit
    input wire logic clr_wr, // One written to the clear bit
    input wire logic src_event, // Raw event pulse of this source
    output logic en_set, // Enable-set state
    output logic irq_pulse // Forwarded event pulse
);
    logic en_set_reg;
    logic en_set_next;
    logic irq_pulse_reg;
    logic irq_pulse_next;

    // Set only under master enable, clear only while set and enabled
    always_comb begin
        en_set_next = en_set_reg;
        if (set_wr && master_en) begin // see [RULE1]
            en_set_next = 1'b1; // see [RULE4]
        end
        if (clr_wr && master_en && en_set_reg) begin // see [RULE3]
            en_set_next = 1'b0;
        end
        irq_pulse_next = src_event && en_set_reg; // see [RULE10]
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            en_set_reg <= 1'b0;
            irq_pulse_reg <= 1'b0;
        end else begin
            en_set_reg <= en_set_next;
            irq_pulse_reg <= irq_pulse_next;
        end
    end

    assign en_set = en_set_reg;
    assign irq_pulse = irq_pulse_reg;

    // A set write without master enable leaves a clear bit clear
    property p_cell_set_gated;
        @(posedge clk_sys) disable iff (reset)
        (set_wr && !master_en && !clr_wr && !en_set_reg) |=> !en_set_reg;
    endproperty
    a_cell_set_gated: assert property (p_cell_set_gated) // see [RULE1]
        else $error("set bit rose without master enable");

    // Enable holds steady when no strobe arrives
    property p_cell_hold;
        @(posedge clk_sys) disable iff (reset)
        (!set_wr && !clr_wr) |=> $stable(en_set_reg);
    endproperty
    a_cell_hold: assert property (p_cell_hold) // see [RULE4]
        else $error("enable changed without a write of one");
endmodule : vpie_enable_cell

// >>> testbench/vpie_top_tb.sv
module vpie_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] src_event, irq_out;
    int fails, num_checks;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    vpie_top i_dut (
        .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .src_event(src_event), .irq_out(irq_out)
    );

    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait for hready; a hung slave ends the run
    task automatic wt;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
            final_report();
        end
    endtask : wt

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= vpie_pkg::HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        wt();
        hsel <= 1'b0;
        htrans <= vpie_pkg::HTRANS_IDLE;
        hwdata <= d;
        wt();
        r = hrdata;
        // Every transfer must end with an OKAY response
        chk({31'h0, hresp}, {31'h0, vpie_pkg::HRESP_OKAY});
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, rd);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask : rc

    // Pulse events, then look at the gated pulse two cycles on
    task automatic ev(input logic [4:0] m, input logic [4:0] exp);
        @(posedge clk_sys);
        src_event <= m;
        @(posedge clk_sys);
        src_event <= 5'h00;
        @(posedge clk_sys);
        #1;
        chk({27'h0, irq_out}, {27'h0, exp});
        @(posedge clk_sys);
        #1;
        chk({27'h0, irq_out}, 32'h0000_0000);
    endtask : ev

    // Main sequence
    initial begin
        fails = 0;
        num_checks = 0;
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = vpie_pkg::HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        src_event = 5'h00;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rc(8'h00, 32'h0000_0000);
        rc(8'h04, 32'h0000_0000);
        rc(8'h08, 32'h0000_0000);
        $display("test reset values done");
        wr(8'h04, 32'hFFFF_FFFF);
        rc(8'h04, 32'h0000_0000);
        ev(5'h1F, 5'h00);
        $display("test set without master done");
        // Master enable goes on before the set writes that follow
        wr(8'h00, 32'h0000_001F);
        wr(8'h04, 32'h0000_0000);
        rc(8'h04, 32'h0000_0000);
        wr(8'h04, 32'h0000_0001);
        rc(8'h04, 32'h0000_0001);
        wr(8'h04, 32'h0000_0000);
        rc(8'h04, 32'h0000_0001);
        wr(8'h04, 32'h0000_001F);
        rc(8'h04, 32'h0000_001F);
        ev(5'h1F, 5'h1F);
        rc(8'h08, 32'h0000_0000);
        $display("test enable sequence done");
        // Clears with master off must be refused
        wr(8'h00, 32'h0000_0000);
        wr(8'h08, 32'h0000_001F);
        rc(8'h04, 32'h0000_001F);
        // Master and set both on before the clear writes that follow
        wr(8'h00, 32'h0000_001F);
        wr(8'h08, 32'h0000_0000);
        rc(8'h04, 32'h0000_001F);
        wr(8'h08, 32'h0000_0001);
        rc(8'h04, 32'h0000_001E);
        wr(8'h08, 32'h0000_0010);
        rc(8'h04, 32'h0000_000E);
        wr(8'h08, 32'h0000_0008);
        rc(8'h04, 32'h0000_0006);
        ev(5'h1F, 5'h06);
        rc(8'h08, 32'h0000_0000);
        $display("test clear gating done");
        wr(8'h0C, 32'hFFFF_FFFF);
        rc(8'h0C, 32'h0000_0000);
        rc(8'h00, 32'h0000_001F);
        rc(8'h04, 32'h0000_0006);
        $display("test unmapped word done");
        wr(8'h08, 32'hFFFF_FFE0);
        rc(8'h04, 32'h0000_0006);
        wr(8'h08, 32'hFFFF_FFFF);
        rc(8'h04, 32'h0000_0000);
        rc(8'h08, 32'h0000_0000);
        $display("test reserved clear bits done");
        final_report();
    end
endmodule : vpie_top_tb
